/* File: ocp_pkg.sv */
package ocp_pkg;
	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [7:0] OCP_OFS_OSC = 8'h00;
	localparam logic [7:0] OCP_OFS_WRITE_LOCK_BIT = 8'h01;
	localparam logic [7:0] OCP_OFS_TEST = 8'h02;
	localparam logic [7:0] OCP_OFS_TRIM = 8'h03;
	localparam logic [7:0] OCP_OFS_CLKS = 8'h04;
	localparam logic [7:0] OCP_OFS_STAT = 8'h05;
	// ****************************************
	// Fields and values
	// ****************************************
	localparam int OCP_BIT_OSCON = 7;
	localparam int OCP_BIT_WIDE = 6;
	localparam int OCP_BIT_PINS = 5;
	localparam logic [7:0] OCP_UNLOCK_KEY = 8'h26;
	localparam logic [4:0] OCP_RATIO_OFF = 5'h00;
	localparam logic [4:0] OCP_TRIM_NOM_LO = 5'h00;
	localparam logic [4:0] OCP_TRIM_NOM_HI = 5'h10;
	localparam logic OCP_LOCK_RST = 1'b1;
	localparam logic OCP_CLKS_RST = 1'b1;
	localparam logic OCP_FLAG_RST = 1'b0;
	localparam logic [7:0] OCP_TEST_RST = 8'h00;
	localparam logic [4:0] OCP_TRIM_RST = 5'h00;
	localparam logic OCP_WIN_NARROW = 1'b0;
	localparam logic [1:0] OCP_WIN_ONE = 2'h1;
	localparam logic [1:0] OCP_WIN_THREE = 2'h3;
	localparam logic [7:0] OCP_ZERO = 8'h00;

	typedef enum logic [1:0] {OCP_TC_NOMINAL, OCP_TC_NEG, OCP_TC_POS} ocp_tc_dir_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ocp_bus_req_t;

	typedef struct packed {
		logic crystal_out_pin_on;
		logic wide;
		logic [4:0] ratio;
	} ocp_osc_cfg_t;
endpackage

/* File: ocp_osc_config_protect.sv */
`timescale 1ns/1ps
// What this block does
// RQ1 - Oscillator config write lands only when unlocked and PLL clock selected.
// RQ2 - Each accepted oscillator config write clears lock and qualified status.
// RQ3 - Bit 7 on: oscillator reference with clock monitor; off: internal RC.
// RQ4 - With oscillator on, loss of oscillation raises a clock monitor reset.
// RQ5 - Qualified status gates use of oscillator clock for bus or timers.
// RQ6 - Bit 6 picks filter window: one VCO cycle or three.
// RQ7 - Software selects wide window when VCO runs above 25 MHz.
// RQ8 - Bit 5 pins-claimed sets once oscillator on, cleared only by reset.
// RQ9 - While claimed, both crystal pins serve only the oscillator.
// RQ10 - Bits 4..0 filter ratio; zero disables adaptive filter, else enabled.
// RQ11 - Software writes half the VCO/oscillator ratio, or zero if fractional.
// RQ12 - Software avoids frequency modulation while the filter is enabled.
// RQ13 - Enabled filter reports clock quality through the qualified bit.
// RQ14 - Writing 0x26 to protection register unlocks; other values lock.
// RQ15 - Lock blocks writes to all protected clock configuration registers.
// RQ16 - Protection register is always readable and writable.
// RQ17 - Factory test register writable only in special mode, always readable.
// RQ18 - Software waits oscillator startup time before pseudo stop.
// RQ19 - Trim codes 00000/10000 nominal, 0xxxx negative, 1xxxx positive.
// RQ20 - Protection register reads lock state in bit 0, zeros above.
module ocp_osc_config_protect #(
	parameter int RATIO_W = 5
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	// Register port
	input wire ocp_pkg::ocp_bus_req_t bus_req,
	output logic [7:0] rd_data,
	// Mode and PLL side
	input wire logic special_mode,
	input wire logic pll_in_tol_raw,
	input wire logic osc_good_raw,
	input wire logic osc_lost_raw,
	// Oscillator and reference control
	output ocp_pkg::ocp_osc_cfg_t osc_cfg,
	output logic ref_from_osc,
	output logic clk_mon_en,
	output logic filter_en,
	output logic [1:0] filter_window_vco,
	output logic crystal_pins_claimed,
	output logic crystal_pins_reserved,
	output logic osc_clk_usable,
	output logic clk_mon_reset,
	output logic pll_clock_selected,
	output logic [4:0] temp_coeff_trim,
	output ocp_pkg::ocp_tc_dir_t tc_direction,
	output logic oscillator_qualified,
	output logic pll_locked
);
	import ocp_pkg::*;

	// Elaboration checks: the fields must pack into one byte register
	if (RATIO_W != 5) begin
		$error("RATIO_W must be 5");
	end
	if (OCP_BIT_PINS != RATIO_W) begin
		$error("ratio field must sit just below the pins bit");
	end
	if (OCP_BIT_WIDE != OCP_BIT_PINS + 1) begin
		$error("window bit must sit just above the pins bit");
	end
	if (OCP_BIT_OSCON != OCP_BIT_WIDE + 1) begin
		$error("enable bit must sit just above the window bit");
	end
	if (OCP_BIT_OSCON > 7) begin
		$error("enable bit lies outside the register byte");
	end
	if (OCP_TRIM_NOM_HI[3:0] != OCP_TRIM_NOM_LO[3:0]) begin
		$error("nominal trim codes must differ in the top bit only");
	end
	if (OCP_OFS_OSC == OCP_OFS_WRITE_LOCK_BIT) begin
		$error("oscillator and lock registers share an offset");
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Status arrives from the analog clock domain, so two stages each
	localparam int SYNC_N = 3;
	logic [SYNC_N-1:0] sync_in;
	logic [SYNC_N-1:0] sync1_r;
	logic [SYNC_N-1:0] sync2_r;
	assign sync_in = {osc_lost_raw, osc_good_raw, pll_in_tol_raw};

	for (genvar g = 0; g < SYNC_N; g++) begin
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				sync1_r[g] <= OCP_FLAG_RST;
				sync2_r[g] <= OCP_FLAG_RST;
			end else if (clk_en) begin
				sync1_r[g] <= sync_in[g];
				sync2_r[g] <= sync1_r[g];
			end
		end
	end

	logic tol_s;
	logic good_s;
	logic lost_s;
	assign tol_s = sync2_r[0];
	assign good_s = sync2_r[1];
	assign lost_s = sync2_r[2];

	// ****************************************
	// Decode
	// ****************************************
	logic lock_r;
	logic osc_on_r;
	logic wide_r;
	logic claimed_r;
	logic clks_r;
	logic [4:0] ratio_r;
	logic [4:0] trim_r;
	logic [7:0] test_r;
	logic lock_st_r;
	logic qual_st_r;

	// Address match, used by the write decode; read select uses its own case
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Write strobe aimed at one register offset
	function automatic logic wr_at(input logic [7:0] o);
		return bus_req.wr && hit(bus_req.addr, o);
	endfunction

	logic [7:0] wa;
	logic [7:0] wd;
	logic unlocked;
	logic wr_write_lock_bit;
	logic wr_osc;
	logic wr_trim;
	logic wr_clks;
	logic wr_test;
	logic filt_on;
	logic qual_src;

	assign wa = bus_req.addr;
	assign wd = bus_req.wdata;
	assign unlocked = !lock_r; // [RQ15]
	// Lock register stays open whatever the lock state
	assign wr_write_lock_bit = wr_at(OCP_OFS_WRITE_LOCK_BIT); // [RQ16]
	assign wr_osc = wr_at(OCP_OFS_OSC) && unlocked && clks_r; // [RQ1]
	assign wr_trim = wr_at(OCP_OFS_TRIM) && unlocked; // [RQ15]
	assign wr_clks = wr_at(OCP_OFS_CLKS) && unlocked; // [RQ15]
	// Special mode is a same-clock level, so no synchroniser
	assign wr_test = wr_at(OCP_OFS_TEST) && special_mode; // [RQ17]
	assign filt_on = ratio_r != OCP_RATIO_OFF; // [RQ10]
	// Without the filter, oscillator on with no loss seen qualifies the clock
	assign qual_src = osc_on_r && (filt_on ? good_s : !lost_s); // [RQ13]

	// ****************************************
	// Next values
	// ****************************************
	logic lock_nxt;
	logic osc_on_nxt;
	logic wide_nxt;
	logic claimed_nxt;
	logic clks_nxt;
	logic [4:0] ratio_nxt;
	logic [4:0] trim_nxt;
	logic [7:0] test_nxt;
	logic lock_st_nxt;
	logic qual_st_nxt;

	// Any key but the magic one relocks, so a stray write fails safe
	assign lock_nxt = (wd != OCP_UNLOCK_KEY); // [RQ14]
	assign osc_on_nxt = wd[OCP_BIT_OSCON]; // [RQ3]
	assign wide_nxt = wd[OCP_BIT_WIDE]; // [RQ6]
	// Claim only rises; nothing but reset releases the pins
	assign claimed_nxt = claimed_r || osc_on_r; // [RQ8]
	assign clks_nxt = wd[0];
	assign ratio_nxt = wd[RATIO_W-1:0]; // [RQ10]
	assign trim_nxt = wd[4:0]; // [RQ19]
	assign test_nxt = wd;
	// Clear wins over a fresh status sample in the write cycle
	assign lock_st_nxt = wr_osc ? 1'b0 : tol_s; // [RQ2]
	assign qual_st_nxt = wr_osc ? 1'b0 : qual_src; // [RQ2] [RQ13]

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lock_r <= OCP_LOCK_RST;
		end else if (clk_en && wr_write_lock_bit) begin
			lock_r <= lock_nxt; // [RQ14]
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			osc_on_r <= OCP_FLAG_RST;
		end else if (clk_en && wr_osc) begin
			osc_on_r <= osc_on_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wide_r <= OCP_WIN_NARROW;
		end else if (clk_en && wr_osc) begin
			wide_r <= wide_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ratio_r <= OCP_RATIO_OFF;
		end else if (clk_en && wr_osc) begin
			ratio_r <= ratio_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			claimed_r <= OCP_FLAG_RST;
		end else if (clk_en) begin
			claimed_r <= claimed_nxt; // [RQ8]
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			trim_r <= OCP_TRIM_RST;
		end else if (clk_en && wr_trim) begin
			trim_r <= trim_nxt;
		end
	end

	// Reset leaves the PLL clock selected, so oscillator writes need only the unlock key
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			clks_r <= OCP_CLKS_RST;
		end else if (clk_en && wr_clks) begin
			clks_r <= clks_nxt;
		end
	end

	// Test byte only holds what was written; it drives nothing here
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			test_r <= OCP_TEST_RST;
		end else if (clk_en && wr_test) begin
			test_r <= test_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lock_st_r <= OCP_FLAG_RST;
		end else if (clk_en) begin
			lock_st_r <= lock_st_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			qual_st_r <= OCP_FLAG_RST;
		end else if (clk_en) begin
			qual_st_r <= qual_st_nxt;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] osc_rd;
	logic [7:0] write_lock_bit_rd;
	logic [7:0] trim_rd;
	logic [7:0] clks_rd;
	logic [7:0] stat_rd;

	assign osc_rd = {osc_on_r, wide_r, claimed_r, ratio_r};
	assign write_lock_bit_rd = {7'h00, lock_r}; // [RQ20]
	assign trim_rd = {3'h0, trim_r};
	assign clks_rd = {7'h00, clks_r};
	assign stat_rd = {6'h00, qual_st_r, lock_st_r};

	logic [7:0] rd_sel;
	always_comb begin
		rd_sel = OCP_ZERO;
		case (wa)
			OCP_OFS_OSC: rd_sel = osc_rd;
			OCP_OFS_WRITE_LOCK_BIT: rd_sel = write_lock_bit_rd; // [RQ16]
			OCP_OFS_TEST: rd_sel = test_r; // [RQ17]
			OCP_OFS_TRIM: rd_sel = trim_rd;
			OCP_OFS_CLKS: rd_sel = clks_rd;
			OCP_OFS_STAT: rd_sel = stat_rd;
			default: rd_sel = OCP_ZERO;
		endcase
	end

	// Zero outside a read cycle while clk_en is high; with clk_en low, rd_data holds its last value
	logic [7:0] rd_nxt;
	assign rd_nxt = bus_req.rd ? rd_sel : OCP_ZERO;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= OCP_ZERO;
		end else if (clk_en) begin
			rd_data <= rd_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic trim_nom;
	assign trim_nom = (trim_r == OCP_TRIM_NOM_LO) ||
		(trim_r == OCP_TRIM_NOM_HI);

	always_comb begin
		if (trim_nom) begin
			tc_direction = OCP_TC_NOMINAL; // [RQ19]
		end else if (trim_r[4]) begin
			tc_direction = OCP_TC_POS; // [RQ19]
		end else begin
			tc_direction = OCP_TC_NEG; // [RQ19]
		end
	end

	assign osc_cfg.crystal_out_pin_on = osc_on_r;
	assign osc_cfg.wide = wide_r;
	assign osc_cfg.ratio = ratio_r;
	assign ref_from_osc = osc_on_r; // [RQ3]
	assign clk_mon_en = osc_on_r; // [RQ3]
	assign clk_mon_reset = osc_on_r && lost_s; // [RQ4]
	assign filter_en = filt_on; // [RQ10]
	assign filter_window_vco = wide_r ? OCP_WIN_THREE : OCP_WIN_ONE; // [RQ6]
	assign crystal_pins_claimed = claimed_r;
	assign crystal_pins_reserved = claimed_r; // [RQ9]
	assign osc_clk_usable = qual_st_r; // [RQ5]
	assign oscillator_qualified = qual_st_r;
	assign pll_locked = lock_st_r;
	assign pll_clock_selected = clks_r;
	assign temp_coeff_trim = trim_r;
endmodule

/* File: ocp_osc_config_protect_assertions.sv */
`timescale 1ns/1ps
module ocp_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Watched ports
	input wire logic clk_en,
	input wire ocp_pkg::ocp_bus_req_t bus_req,
	input wire logic [7:0] rd_data,
	input wire ocp_pkg::ocp_osc_cfg_t osc_cfg,
	input wire logic ref_from_osc,
	input wire logic filter_en,
	input wire logic [1:0] filter_window_vco,
	input wire logic crystal_pins_claimed,
	input wire logic crystal_pins_reserved,
	input wire logic clk_mon_reset,
	input wire logic oscillator_qualified,
	input wire logic [4:0] temp_coeff_trim,
	input wire ocp_pkg::ocp_tc_dir_t tc_direction
);
	import ocp_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_ref_follows: assert property (ref_from_osc == osc_cfg.crystal_out_pin_on)
		else $error("reference source wrong");
	a_mon_gate: assert property (clk_mon_reset |-> osc_cfg.crystal_out_pin_on)
		else $error("monitor reset while oscillator off");
	a_window_width: assert property (filter_window_vco ==
		(osc_cfg.wide ? OCP_WIN_THREE : OCP_WIN_ONE))
		else $error("filter window wrong");
	a_pins_set: assert property (clk_en && osc_cfg.crystal_out_pin_on |=>
		crystal_pins_claimed) else $error("pins not claimed");
	a_pins_sticky: assert property ($fell(crystal_pins_claimed) == 0)
		else $error("pins claim dropped");
	a_pins_reserve: assert property (crystal_pins_reserved ==
		crystal_pins_claimed) else $error("pins reservation wrong");
	a_filter_on: assert property (filter_en == (osc_cfg.ratio != 5'h00))
		else $error("filter enable wrong");
	a_cfg_clear: assert property ($changed(osc_cfg) |->
		!oscillator_qualified) else $error("status kept after write");
	a_lock_read: assert property (clk_en && bus_req.rd &&
		bus_req.addr == OCP_OFS_WRITE_LOCK_BIT |=> rd_data[7:1] == 7'h00)
		else $error("lock read upper bits set");
	a_trim_nominal: assert property (temp_coeff_trim[3:0] == 4'h0 |->
		tc_direction == OCP_TC_NOMINAL) else $error("trim not nominal");
endmodule
bind ocp_osc_config_protect ocp_chk chk_u (.clk_sys, .arst_n, .clk_en,
	.bus_req, .rd_data, .osc_cfg, .ref_from_osc, .filter_en,
	.filter_window_vco, .crystal_pins_claimed, .crystal_pins_reserved,
	.clk_mon_reset, .oscillator_qualified, .temp_coeff_trim, .tc_direction);

/* File: ocp_crystal_out_pin_model.sv */
`timescale 1ns/1ps
module ocp_crystal_out_pin_model #(
	parameter int STARTUP = 6
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Crystal side
	input wire logic osc_on,
	input wire logic kill,
	output logic osc_good,
	output logic osc_lost,
	output logic pll_tol
);
	int cnt;
	// Swing is only clean after a startup time
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) cnt <= 0;
		else if (!osc_on) cnt <= 0;
		else if (cnt < STARTUP) cnt <= cnt + 1;
	end
	assign osc_good = osc_on && cnt == STARTUP && !kill;
	assign osc_lost = osc_on && kill;
	assign pll_tol = !kill;
endmodule

/* File: tb_osc_config_protect.sv */
`timescale 1ns/1ps
module tb_osc_config_protect;
	import ocp_pkg::*;
	logic clk_sys, arst_n, clk_en, special_mode, kill, tol, good, lost;
	logic ref_from_osc, clk_mon_en, filter_en, crystal_pins_claimed;
	logic crystal_pins_reserved, osc_clk_usable, clk_mon_reset;
	logic pll_clock_selected, oscillator_qualified, pll_locked;
	logic [7:0] rd_data;
	logic [1:0] filter_window_vco;
	logic [4:0] temp_coeff_trim;
	ocp_bus_req_t bus_req;
	ocp_osc_cfg_t osc_cfg;
	ocp_tc_dir_t tc_direction;
	int fail_count, comparisons, cyc;
	ocp_osc_config_protect dut_u (.clk_sys, .arst_n, .clk_en, .bus_req,
		.rd_data, .special_mode, .pll_in_tol_raw(tol), .osc_good_raw(good),
		.osc_lost_raw(lost), .osc_cfg, .ref_from_osc, .clk_mon_en, .filter_en,
		.filter_window_vco, .crystal_pins_claimed, .crystal_pins_reserved,
		.osc_clk_usable, .clk_mon_reset, .pll_clock_selected, .temp_coeff_trim,
		.tc_direction, .oscillator_qualified, .pll_locked);
	ocp_crystal_out_pin_model crystal_out_pin_u (.clk_sys, .arst_n, .osc_on(osc_cfg.crystal_out_pin_on), .kill,
		.osc_good(good), .osc_lost(lost), .pll_tol(tol));
	always #4 clk_sys = ~clk_sys;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Gap cycle after each strobe so no signal is driven twice per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		@(negedge clk_sys);
		chk(rd_data, e);
		@(posedge clk_sys);
	endtask
	task automatic finish_test();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic t_lock();
		rd(OCP_OFS_WRITE_LOCK_BIT, 8'h01);
		wr(OCP_OFS_OSC, 8'h80);
		rd(OCP_OFS_OSC, 8'h00);
		wr(OCP_OFS_TRIM, 8'h1f);
		rd(OCP_OFS_TRIM, 8'h00);
		wr(OCP_OFS_WRITE_LOCK_BIT, OCP_UNLOCK_KEY);
		rd(OCP_OFS_WRITE_LOCK_BIT, 8'h00);
		wr(OCP_OFS_WRITE_LOCK_BIT, 8'h27);
		rd(OCP_OFS_WRITE_LOCK_BIT, 8'h01);
		wr(OCP_OFS_WRITE_LOCK_BIT, OCP_UNLOCK_KEY);
		wr(OCP_OFS_CLKS, 8'h00);
		chk({7'h00, pll_clock_selected}, 8'h00);
		wr(OCP_OFS_OSC, 8'h80);
		rd(OCP_OFS_OSC, 8'h00);
		wr(OCP_OFS_CLKS, 8'h01);
		rd(OCP_OFS_CLKS, 8'h01);
		$display("lock done");
	endtask
	task automatic t_osc();
		// Fast VCO assumed, so wide window
		wr(OCP_OFS_OSC, 8'h41);
		rd(OCP_OFS_OSC, 8'h41);
		chk({6'h00, filter_window_vco}, 8'h03);
		// Ratio 2 is an integer half ratio, no modulation
		wr(OCP_OFS_OSC, 8'h82);
		rd(OCP_OFS_OSC, 8'ha2);
		chk({7'h00, ref_from_osc}, 8'h01);
		chk({7'h00, clk_mon_en}, 8'h01);
		chk({7'h00, filter_en}, 8'h01);
		// Startup wait before any low-power use
		for (int i = 0; i < 40 && oscillator_qualified !== 1'b1; i++)
			@(posedge clk_sys);
		chk({7'h00, oscillator_qualified}, 8'h01);
		chk({7'h00, osc_clk_usable}, 8'h01);
		rd(OCP_OFS_STAT, 8'h03);
		bus_req <= '{OCP_OFS_OSC, 8'h82, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		#1 chk({7'h00, oscillator_qualified}, 8'h00);
		chk({7'h00, pll_locked}, 8'h00);
		chk({7'h00, osc_clk_usable}, 8'h00);
		kill <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk({7'h00, clk_mon_reset}, 8'h01);
		kill <= 1'b0;
		wr(OCP_OFS_OSC, 8'h00);
		rd(OCP_OFS_OSC, 8'h20);
		chk({7'h00, crystal_pins_reserved}, 8'h01);
		chk({7'h00, crystal_pins_claimed}, 8'h01);
		$display("osc done");
	endtask
	task automatic t_trim();
		logic [4:0] codes[6] = '{5'h00, 5'h10, 5'h01, 5'h0f, 5'h11, 5'h1f};
		ocp_tc_dir_t d;
		wr(OCP_OFS_TEST, 8'h5a);
		rd(OCP_OFS_TEST, 8'h00);
		special_mode <= 1'b1;
		wr(OCP_OFS_TEST, 8'h5a);
		rd(OCP_OFS_TEST, 8'h5a);
		special_mode <= 1'b0;
		rd(8'h40, 8'h00);
		foreach (codes[k]) begin
			d = codes[k][3:0] == 4'h0 ? OCP_TC_NOMINAL :
				(codes[k][4] ? OCP_TC_POS : OCP_TC_NEG);
			wr(OCP_OFS_TRIM, {3'h0, codes[k]});
			chk({6'h00, tc_direction}, {6'h00, d});
			chk({3'h0, temp_coeff_trim}, {3'h0, codes[k]});
		end
		// Frozen clock enable must drop an unlocked trim write
		clk_en <= 1'b0;
		wr(OCP_OFS_TRIM, 8'h05);
		clk_en <= 1'b1;
		rd(OCP_OFS_TRIM, 8'h1f);
		$display("trim done");
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		clk_sys = 1'b0;
		arst_n = 1'b0;
		clk_en = 1'b1;
		special_mode = 1'b0;
		kill = 1'b0;
		bus_req = '0;
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_lock();
		t_osc();
		t_trim();
		finish_test();
	end
endmodule
